// ==== rtl/ext_ctrl_map.svh ====
// offsets, field positions, masks, reset values and buffer constants of the extended control register
`ifndef EXT_CTRL_MAP_SVH
`define EXT_CTRL_MAP_SVH

`define EXT_CTRL_OFFSET 5'h10
`define MGMT_ADDR_WIDTH 5
`define REG_WIDTH 16

`define BIT_OVR_EN 15
`define BIT_ADDR_HI 10
`define BIT_ADDR_LO 6
`define BIT_SCR_TEST 5
`define BIT_LINE_CODE 3
`define BIT_INV_CODE 2
`define BIT_SCR_DIS 0

`define RESERVED_MASK 16'h7812
`define READ_ONLY_MASK 16'h07C0
`define DEFAULT_PROTECTED 16'h0001
`define NO_BITS 16'h0000

`define RST_OVR_EN 1'b0
`define RST_SCR_TEST 1'b0
`define RST_LINE_CODE 1'b1
`define RST_INV_CODE 1'b0
`define RST_SCR_DIS 1'b0
`define RST_PHY_ADDR 5'h00
`define RST_SYMBOL 5'h00

`define BUF_DEPTH 2
`define BUF_FULL 2'h2
`define BUF_EMPTY 2'h0
`define BUF_ONE 2'h1

`endif

// ==== rtl/ext_ctrl_pkg.sv ====
// types shared by the extended control register and its symbol encoder
package ext_ctrl_pkg;

    typedef logic [3:0] nibble_t;
    typedef logic [4:0] symbol_t;
    typedef logic [15:0] reg_word_t;

    typedef enum logic [1:0] {
        code_standard = 2'h1,
        code_alternate = 2'h2
    } code_mode_t;

endpackage : ext_ctrl_pkg

// ==== rtl/nibble_encoder.sv ====
// nibble to five-bit symbol translation, standard or alternate table
`timescale 1ns/1ps
`include "ext_ctrl_map.svh"

module nibble_encoder
    import ext_ctrl_pkg::*;
(
    input wire nibble_t nibble,
    input wire logic tx_err,
    input wire logic alt_enable,
    output symbol_t symbol
);

    code_mode_t mode;
    symbol_t std_sym;
    symbol_t alt_sym;

    // alternate table only when the test bit and the error input are both high
    assign mode = (alt_enable && tx_err) ? code_alternate : code_standard;

    always_comb
    begin
        case (nibble)
            4'h0: std_sym = 5'h1E;
            4'h1: std_sym = 5'h09;
            4'h2: std_sym = 5'h14;
            4'h3: std_sym = 5'h15;
            4'h4: std_sym = 5'h0A;
            4'h5: std_sym = 5'h0B;
            4'h6: std_sym = 5'h0E;
            4'h7: std_sym = 5'h0F;
            4'h8: std_sym = 5'h12;
            4'h9: std_sym = 5'h13;
            4'hA: std_sym = 5'h16;
            4'hB: std_sym = 5'h17;
            4'hC: std_sym = 5'h1A;
            4'hD: std_sym = 5'h1B;
            4'hE: std_sym = 5'h1C;
            default: std_sym = 5'h1D;
        endcase
    end

    always_comb
    begin
        case (nibble)
            4'h8: alt_sym = 5'h00;
            4'h9: alt_sym = 5'h0D;
            4'hA: alt_sym = 5'h0C;
            4'hB: alt_sym = 5'h11;
            4'hC: alt_sym = 5'h10;
            4'hD: alt_sym = 5'h19;
            4'hE: alt_sym = 5'h18;
            4'hF: alt_sym = 5'h1F;
            default: alt_sym = {1'b0, nibble};
        endcase
    end

    always_comb
    begin
        case (mode)
            code_alternate: symbol = alt_sym;
            default: symbol = std_sym;
        endcase
    end

endmodule : nibble_encoder

// ==== rtl/phy_extended_control_reg.sv ====
// extended control register of a 10/100 transceiver with its transmit symbol path
//
// What this block does
// - set override enable lets the next management write change protected bits
// - override enable clears after a write to any other register, and takes bit fifteen of a write to its own register
// - reserved bits fourteen to eleven, four and one read as zero
// - port address sampled from the status pins at hardware reset, then held
// - software reset leaves the sampled port address unchanged
// - scrambler test bit forces descrambler lock loss and resynchronisation
// - line code bit selects nrz when zero, nrzi when one, resets to one
// - invalid code bit clear gives standard 4b5b translation whatever the error input
// - invalid code bit set with error input high uses the alternate table
// - alternate table maps nibbles zero to seven to leading zero codes
// - alternate table maps upper nibbles to their listed fixed codes
// - scrambler disable bit bypasses transmit scrambler and receive descrambler
// - scrambler and descrambler act only at 100 mb/s
`timescale 1ns/1ps
`include "ext_ctrl_map.svh"

module phy_extended_control_reg
    import ext_ctrl_pkg::*;
#(
    parameter int ADDR_BITS = 5,
    parameter int BUF_ENTRIES = 2,
    parameter logic [15:0] PROTECTED_MASK = `DEFAULT_PROTECTED
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic soft_rst,
    input wire logic mgmt_wr_en,
    input wire logic mgmt_rd_en,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rdata_valid,
    output logic override_write_ok,
    input wire logic addr4_rxled_pin,
    input wire logic addr3_txled_pin,
    input wire logic addr2_linkled_pin,
    input wire logic addr1_colled_pin,
    input wire logic addr0_actled_pin,
    output logic [4:0] phy_address,
    input wire logic speed_100,
    output logic descrambler_unlock,
    output logic lock_drop_pulse,
    output logic scrambler_enable,
    output logic descrambler_enable,
    output logic nrzi_select,
    output logic invalid_code_test,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire nibble_t tx_nibble,
    input wire logic tx_err,
    output logic sym_valid,
    input wire logic sym_ready,
    output symbol_t sym_code
);

    // parameter checks
    generate
        if (ADDR_BITS != `MGMT_ADDR_WIDTH)
        begin : g_bad_addr
            $error("port address width must be five");
        end
        if ((`BIT_ADDR_HI - `BIT_ADDR_LO + 1) != ADDR_BITS)
        begin : g_bad_field
            $error("address field width must match the port address");
        end
        if (BUF_ENTRIES != `BUF_DEPTH)
        begin : g_bad_depth
            $error("symbol buffer holds exactly two entries");
        end
        if ((PROTECTED_MASK & (`RESERVED_MASK | `READ_ONLY_MASK)) != `NO_BITS)
        begin : g_bad_mask
            $error("protected bits must be writable bits");
        end
        if (PROTECTED_MASK[`BIT_OVR_EN])
        begin : g_bad_ovr
            $error("override enable cannot itself be protected");
        end
    endgenerate

    // register fields
    logic ovr_en;
    logic scr_test;
    logic line_code;
    logic inv_code;
    logic scr_dis;
    logic [4:0] phy_addr;
    logic addr_taken;

    // read path
    logic [15:0] rdata;
    logic rvalid;

    // symbol buffer
    symbol_t buf_mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;

    // decode and next values
    wire hit_wr;
    wire hit_rd;
    wire other_wr;
    wire [15:0] cur_word;
    wire [15:0] keep_mask;
    wire [15:0] merged;
    wire next_ovr_en;
    wire next_scr_test;
    wire next_line_code;
    wire next_inv_code;
    wire next_scr_dis;
    wire [4:0] strap_addr;
    wire [4:0] addr_field;
    wire push;
    wire pop;
    wire lock_rise;
    symbol_t enc_sym;

    assign hit_wr = mgmt_wr_en && (mgmt_addr == `EXT_CTRL_OFFSET);
    assign hit_rd = mgmt_rd_en && (mgmt_addr == `EXT_CTRL_OFFSET);
    assign other_wr = mgmt_wr_en && (mgmt_addr != `EXT_CTRL_OFFSET);

    // readback word, reserved bits forced to zero
    assign cur_word = ({ovr_en, 4'h0, addr_field, scr_test, 1'b0, line_code, inv_code,
                        1'b0, scr_dis}) & ~`RESERVED_MASK;

    // protected bits keep their value unless the override is armed
    assign keep_mask = ovr_en ? `NO_BITS : PROTECTED_MASK;
    assign merged = (mgmt_wdata & ~keep_mask) | (cur_word & keep_mask);

    // override enable: takes bit fifteen of its own write, cleared by any other write
    assign next_ovr_en = hit_wr ? merged[`BIT_OVR_EN] :
                         (other_wr ? 1'b0 : ovr_en);
    assign next_scr_test = hit_wr ? merged[`BIT_SCR_TEST] : scr_test;
    assign next_line_code = hit_wr ? merged[`BIT_LINE_CODE] : line_code;
    assign next_inv_code = hit_wr ? merged[`BIT_INV_CODE] : inv_code;
    assign next_scr_dis = hit_wr ? merged[`BIT_SCR_DIS] : scr_dis;

    assign strap_addr = {addr4_rxled_pin, addr3_txled_pin, addr2_linkled_pin,
                         addr1_colled_pin, addr0_actled_pin};

    // reads see the pins until the first edge after reset has latched them
    assign addr_field = addr_taken ? phy_addr : strap_addr;

    assign lock_rise = hit_wr && merged[`BIT_SCR_TEST] && !scr_test;

    // writable fields; soft reset restores them but not the address
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ovr_en <= `RST_OVR_EN;
            scr_test <= `RST_SCR_TEST;
            line_code <= `RST_LINE_CODE;
            inv_code <= `RST_INV_CODE;
            scr_dis <= `RST_SCR_DIS;
        end
        else if (soft_rst)
        begin
            ovr_en <= `RST_OVR_EN;
            scr_test <= `RST_SCR_TEST;
            line_code <= `RST_LINE_CODE;
            inv_code <= `RST_INV_CODE;
            scr_dis <= `RST_SCR_DIS;
        end
        else
        begin
            ovr_en <= next_ovr_en;
            scr_test <= next_scr_test;
            line_code <= next_line_code;
            inv_code <= next_inv_code;
            scr_dis <= next_scr_dis;
        end
    end

    // strap capture on the first edge after hardware reset release
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            phy_addr <= `RST_PHY_ADDR;
            addr_taken <= 1'b0;
        end
        else if (!addr_taken)
        begin
            phy_addr <= strap_addr;
            addr_taken <= 1'b1;
        end
    end

    // registered read answer
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdata <= `NO_BITS;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= hit_rd;
            if (hit_rd)
            begin
                rdata <= cur_word;
            end
        end
    end

    // one-cycle notice when test mode is newly entered
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            lock_drop_pulse <= 1'b0;
        end
        else
        begin
            lock_drop_pulse <= lock_rise && !soft_rst;
        end
    end

    assign mgmt_rdata = rdata;
    assign mgmt_rdata_valid = rvalid;
    assign override_write_ok = ovr_en;
    assign phy_address = phy_addr;

    // datapath controls
    assign descrambler_unlock = scr_test && speed_100;
    assign scrambler_enable = speed_100 && !scr_dis;
    assign descrambler_enable = speed_100 && !scr_dis;
    assign nrzi_select = line_code;
    assign invalid_code_test = inv_code;

    // symbol translation at buffer entry
    nibble_encoder u_encoder (
        .nibble(tx_nibble),
        .tx_err(tx_err),
        .alt_enable(inv_code),
        .symbol(enc_sym)
    );

    // two-entry buffer between the mii side and the symbol consumer
    assign tx_ready = (count != `BUF_FULL);
    assign sym_valid = (count != `BUF_EMPTY);
    assign push = tx_valid && tx_ready;
    assign pop = sym_valid && sym_ready;
    assign sym_code = buf_mem[rd_ptr];

    genvar g;
    generate
        for (g = 0; g < `BUF_DEPTH; g = g + 1)
        begin : g_entry
            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                begin
                    buf_mem[g] <= `RST_SYMBOL;
                end
                else if (push && (wr_ptr == 1'(g)))
                begin
                    buf_mem[g] <= enc_sym;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= `BUF_EMPTY;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= !wr_ptr;
            end
            if (pop)
            begin
                rd_ptr <= !rd_ptr;
            end
            if (push && !pop)
            begin
                count <= count + `BUF_ONE;
            end
            else if (pop && !push)
            begin
                count <= count - `BUF_ONE;
            end
        end
    end

endmodule : phy_extended_control_reg

// ==== testbench/ext_ctrl_checker.sv ====
// port assertions for the extended control register
`timescale 1ns/1ps
module ext_ctrl_checker
    import ext_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic soft_rst,
    input wire logic mgmt_wr_en,
    input wire logic mgmt_rd_en,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rdata_valid,
    input wire logic override_write_ok,
    input wire logic [4:0] phy_address,
    input wire logic speed_100,
    input wire logic descrambler_unlock,
    input wire logic lock_drop_pulse,
    input wire logic scrambler_enable,
    input wire logic descrambler_enable,
    input wire logic sym_valid,
    input wire logic sym_ready,
    input wire symbol_t sym_code
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    AST_RD_ANSWER: assert property (mgmt_rd_en && mgmt_addr == 5'h10 |=> mgmt_rdata_valid)
        else $error("read not answered");
    AST_OVR_SET: assert property (mgmt_wr_en && mgmt_addr == 5'h10 && mgmt_wdata[15] && !soft_rst |=> override_write_ok)
        else $error("override enable not set");
    AST_OVR_CLEAR: assert property (override_write_ok && mgmt_wr_en && mgmt_addr != 5'h10 |=> !override_write_ok)
        else $error("override enable not cleared");
    AST_RSV_ZERO: assert property (mgmt_rdata_valid |-> (mgmt_rdata & 16'h7812) == 16'h0000)
        else $error("reserved bits read nonzero");
    AST_ADDR_FIELD: assert property (mgmt_rdata_valid |-> mgmt_rdata[10:6] == phy_address)
        else $error("address field differs");
    AST_OVR_SELF_CLEAR: assert property (mgmt_wr_en && mgmt_addr == 5'h10 && !mgmt_wdata[15] |=> !override_write_ok)
        else $error("override enable not cleared by own write");
    AST_LOCK_PULSE: assert property (mgmt_wr_en && mgmt_addr == 5'h10 && mgmt_wdata[5] && speed_100 && !descrambler_unlock && !soft_rst |=> lock_drop_pulse)
        else $error("lock loss pulse missing");
    AST_ADDR_HOLD: assert property (!$past(rst, 2) |-> $stable(phy_address))
        else $error("address changed after reset");
    AST_PROT_HOLD: assert property (!override_write_ok && !soft_rst && speed_100 ##1 speed_100 |-> $stable(scrambler_enable))
        else $error("protected bit changed");
    AST_SPEED_GATE: assert property (!speed_100 |-> !scrambler_enable && !descrambler_enable && !descrambler_unlock)
        else $error("scrambler active at low speed");
    AST_UNLOCK: assert property (mgmt_wr_en && mgmt_addr == 5'h10 && mgmt_wdata[5] && !soft_rst && speed_100 ##1 speed_100 |-> descrambler_unlock)
        else $error("lock loss not forced");
    AST_SYM_HOLD: assert property (sym_valid && !sym_ready |=> sym_valid && $stable(sym_code))
        else $error("symbol dropped under stall");
endmodule : ext_ctrl_checker

bind phy_extended_control_reg ext_ctrl_checker u_chk (.*);

// ==== testbench/mgmt_model.sv ====
// station manager model driving the management strobes
`timescale 1ns/1ps
module mgmt_model (
    input wire logic clock,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rdata_valid,
    output logic mgmt_wr_en = 1'b0,
    output logic mgmt_rd_en = 1'b0,
    output logic [4:0] mgmt_addr = 5'h00,
    output logic [15:0] mgmt_wdata = 16'h0000
);
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock) #1;
        mgmt_wr_en = 1'b1;
        mgmt_addr = a;
        mgmt_wdata = d & ~16'h7812;
        @(posedge clock) #1;
        mgmt_wr_en = 1'b0;
        mgmt_wdata = ~mgmt_wdata;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic ok, output logic [15:0] d);
        @(posedge clock) #1;
        mgmt_rd_en = 1'b1;
        mgmt_addr = a;
        @(posedge clock) #1;
        mgmt_rd_en = 1'b0;
        ok = mgmt_rdata_valid;
        d = mgmt_rdata;
    endtask : rd
endmodule : mgmt_model

// ==== testbench/phy_extended_control_reg_tb.sv ====
// self-checking bench for the extended control register
`timescale 1ns/1ps
module phy_extended_control_reg_tb;
    import ext_ctrl_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic soft_rst = 1'b0;
    logic speed_100 = 1'b1;
    logic tx_valid = 1'b0;
    logic tx_err = 1'b0;
    logic sym_ready = 1'b0;
    nibble_t tx_nibble = 4'h0;
    logic [4:0] strap = 5'h15;
    logic mgmt_wr_en, mgmt_rd_en, mgmt_rdata_valid, override_write_ok, tx_ready, sym_valid;
    logic descrambler_unlock, lock_drop_pulse, scrambler_enable, descrambler_enable;
    logic nrzi_select, invalid_code_test;
    logic [4:0] mgmt_addr, phy_address;
    logic [15:0] mgmt_wdata, mgmt_rdata;
    symbol_t sym_code;
    int errors = 0;
    int check_count = 0;
    phy_extended_control_reg u_dut (.addr4_rxled_pin(strap[4]), .addr3_txled_pin(strap[3]),
        .addr2_linkled_pin(strap[2]), .addr1_colled_pin(strap[1]),
        .addr0_actled_pin(strap[0]), .*);
    mgmt_model u_mgr (.*);
    always #5 clock = ~clock;
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic waitfor(input bit want_sym);
        for (int i = 0; i < 9 && (want_sym ? sym_valid : tx_ready) !== 1'b1; i++)
            @(posedge clock) #1;
        if ((want_sym ? sym_valid : tx_ready) !== 1'b1)
        begin
            errors++;
            $display("BAD %s expected 1 seen 0", want_sym ? "sym_valid" : "tx_ready");
            close_out();
        end
    endtask : waitfor
    task automatic reg_is(input logic [15:0] exp);
        logic ok;
        logic [15:0] d;
        u_mgr.rd(5'h10, ok, d);
        check("valid", 16'h0001, {15'h0000, ok});
        check("word", exp, d);
    endtask : reg_is
    task automatic push(input nibble_t v);
        @(posedge clock) #1;
        tx_valid = 1'b1;
        tx_nibble = v;
        waitfor(1'b0);
        @(posedge clock) #1;
        tx_valid = 1'b0;
    endtask : push
    task automatic pop(input symbol_t exp);
        @(posedge clock) #1;
        waitfor(1'b1);
        check("symbol", 16'(exp), 16'(sym_code));
        sym_ready = 1'b1;
        @(posedge clock) #1;
        sym_ready = 1'b0;
    endtask : pop
    task automatic t_prot();
        logic ok;
        logic [15:0] d;
        reg_is(16'h0548);
        check("addr", 16'h0015, 16'(phy_address));
        u_mgr.wr(5'h10, 16'h002D);
        check("pulse", 16'h0001, 16'(lock_drop_pulse));
        check("invcode", 16'h0001, 16'(invalid_code_test));
        reg_is(16'h056C);
        check("unlock", 16'h0001, 16'(descrambler_unlock));
        u_mgr.wr(5'h10, 16'h8008);
        check("ovr", 16'h0001, 16'(override_write_ok));
        u_mgr.wr(5'h10, 16'h0009);
        reg_is(16'h0549);
        u_mgr.wr(5'h10, 16'h8008);
        u_mgr.wr(5'h11, 16'h0000);
        check("ovr", 16'h0000, 16'(override_write_ok));
        u_mgr.wr(5'h10, 16'h0008);
        reg_is(16'h0549);
        u_mgr.wr(5'h10, 16'h8008);
        u_mgr.wr(5'h10, 16'h0008);
        check("scr", 16'h0001, 16'(scrambler_enable));
        speed_100 = 1'b0;
        @(posedge clock) #1;
        check("dscr", 16'h0000, 16'(descrambler_enable));
        check("scr10", 16'h0000, 16'(scrambler_enable));
        speed_100 = 1'b1;
        u_mgr.rd(5'h11, ok, d);
        check("unmapped", 16'h0000, 16'(ok));
        u_mgr.wr(5'h10, 16'h0024);
        check("nrzi", 16'h0000, 16'(nrzi_select));
        @(posedge clock) #1 soft_rst = 1'b1;
        @(posedge clock) #1 soft_rst = 1'b0;
        reg_is(16'h0548);
        $display("done registers");
    endtask : t_prot
    task automatic t_codes();
        symbol_t std[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
            5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
        symbol_t alt[16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
            5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1F};
        for (int m = 0; m < 3; m++)
        begin
            u_mgr.wr(5'h10, (m != 0) ? 16'h000C : 16'h0008);
            tx_err = (m != 2);
            for (int n = 0; n < 16; n++)
            begin
                push(n[3:0]);
                pop((m == 1) ? alt[n] : std[n]);
            end
        end
        push(4'hF);
        push(4'hE);
        check("full", 16'h0000, 16'(tx_ready));
        pop(5'h1D);
        pop(5'h1C);
        $display("done symbols");
    endtask : t_codes
    task automatic t_rearm();
        @(posedge clock) #1;
        rst = 1'b1;
        strap = 5'h0A;
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        reg_is(16'h0288);
        check("addr", 16'h000A, 16'(phy_address));
        $display("done hardware reset");
    endtask : t_rearm
    initial
    begin
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        t_prot();
        t_codes();
        t_rearm();
        close_out();
    end
endmodule : phy_extended_control_reg_tb
